// ### core/mis_core.v
// execution unit for one instruction per cycle, memory byte supplied by the caller
`include "mis_regs.vh"
module mis_core #(
   parameter PC_W = 12,
   parameter WD_W = 8,
   parameter PS_W = 8
)(
   // clock and reset
   input  wire            clk,
   input  wire            rst,
   // instruction issue
   input  wire            op_valid,
   input  wire [4:0]      op_code,
   input  wire [7:0]      mem_data,
   input  wire [7:0]      imm_data,
   input  wire [2:0]      bit_sel,
   input  wire [PC_W-1:0] target_addr,
   // memory write back
   output reg             mem_we_r,
   output reg  [7:0]      mem_wdata_r,
   // stack push
   output reg             push_r,
   output reg  [PC_W-1:0] push_data_r,
   // state
   output reg  [PC_W-1:0] pc_r,
   output reg  [7:0]      working_register_r,
   output reg             result_null_flag_r,
   output reg             bit_seven_out_r,
   output reg             half_carry_flag_r,
   output reg             signed_wrap_flag_r,
   output reg             powerdown_flag_r,
   output reg             timeout_flag_r,
   output reg             low_nibble_adjust_out_r,
   output reg             halted_r,
   output reg  [WD_W-1:0] watchdog_counter_r,
   output reg  [PS_W-1:0] prescaler_r
);

   // =====================================
   // arithmetic
   wire       use_imm = (op_code == `MIS_OP_ADDI) || (op_code == `MIS_OP_ANDI);
   wire [7:0] opnd    = use_imm ? imm_data : mem_data;
   wire       cin     = (op_code == `MIS_OP_ADC) || (op_code == `MIS_OP_ADC_MEM) ? bit_seven_out_r : 1'b0;
   wire [4:0] lo_sum  = {1'b0, working_register_r[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
   wire [8:0] sum     = {1'b0, working_register_r} + {1'b0, opnd} + {8'h00, cin};
   wire       wrap    = (working_register_r[7] == opnd[7]) && (sum[7] != opnd[7]);
   wire [7:0] andv    = working_register_r & opnd;
   wire [7:0] incv    = mem_data + 8'h01;
   wire [7:0] decv    = mem_data - 8'h01;
   wire [7:0] cplv    = ~mem_data;
   wire [7:0] bclr    = mem_data & ~(8'h01 << bit_sel);

   // decimal adjust
   wire       lo_fix  = (working_register_r[3:0] > `MIS_BCD_LIMIT) || half_carry_flag_r;
   wire [3:0] lo_nib  = lo_fix ? working_register_r[3:0] + `MIS_BCD_FIX : working_register_r[3:0];
   wire       lo_adj  = lo_fix ? ~half_carry_flag_r : 1'b0;
   wire [4:0] hi_pre  = {1'b0, working_register_r[7:4]} + {4'h0, lo_adj};
   wire       hi_fix  = (hi_pre > {1'b0, `MIS_BCD_LIMIT}) || bit_seven_out_r;
   wire [3:0] hi_nib  = hi_fix ? hi_pre[3:0] + `MIS_BCD_FIX : hi_pre[3:0];

   reg        pre1_r;
   reg        pre2_r;
   wire       wd_both = (op_code == `MIS_OP_WDC1 && pre2_r) || (op_code == `MIS_OP_WDC2 && pre1_r);

   // =====================================
   // sequential
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         mem_we_r                <= 1'b0;
         mem_wdata_r             <= `MIS_RST_BYTE;
         push_r                  <= 1'b0;
         push_data_r             <= `MIS_RST_PC;
         pc_r                    <= `MIS_RST_PC;
         working_register_r      <= `MIS_RST_BYTE;
         result_null_flag_r      <= 1'b0;
         bit_seven_out_r         <= 1'b0;
         half_carry_flag_r       <= 1'b0;
         signed_wrap_flag_r      <= 1'b0;
         powerdown_flag_r        <= 1'b0;
         timeout_flag_r          <= 1'b0;
         low_nibble_adjust_out_r <= 1'b0;
         halted_r                <= 1'b0;
         watchdog_counter_r      <= {WD_W{1'b0}};
         prescaler_r             <= {PS_W{1'b0}};
         pre1_r                  <= 1'b0;
         pre2_r                  <= 1'b0;
      end
      else
      begin
         mem_we_r <= 1'b0;
         push_r   <= 1'b0;
         if (!halted_r)
         begin
            prescaler_r <= prescaler_r + {{(PS_W-1){1'b0}}, 1'b1};
            if (&prescaler_r)
               watchdog_counter_r <= watchdog_counter_r + {{(WD_W-1){1'b0}}, 1'b1};
         end
         if (op_valid && !halted_r)
         begin
            pc_r <= pc_r + {{(PC_W-1){1'b0}}, 1'b1};
            case (op_code)
               `MIS_OP_ADC, `MIS_OP_ADC_MEM, `MIS_OP_ADD, `MIS_OP_ADDI, `MIS_OP_ADD_MEM:
               begin
                  if (op_code == `MIS_OP_ADC_MEM || op_code == `MIS_OP_ADD_MEM)
                  begin
                     mem_we_r    <= 1'b1;
                     mem_wdata_r <= sum[7:0];
                  end
                  else
                     working_register_r <= sum[7:0];
                  result_null_flag_r <= (sum[7:0] == 8'h00);
                  bit_seven_out_r    <= sum[8];
                  half_carry_flag_r  <= lo_sum[4];
                  signed_wrap_flag_r <= wrap;
               end
               `MIS_OP_AND, `MIS_OP_ANDI, `MIS_OP_AND_MEM:
               begin
                  if (op_code == `MIS_OP_AND_MEM)
                  begin
                     mem_we_r    <= 1'b1;
                     mem_wdata_r <= andv;
                  end
                  else
                     working_register_r <= andv;
                  result_null_flag_r <= (andv == 8'h00);
               end
               `MIS_OP_CALL:
               begin
                  push_r      <= 1'b1;
                  push_data_r <= pc_r + {{(PC_W-1){1'b0}}, 1'b1};
                  pc_r        <= target_addr;
               end
               `MIS_OP_JMP:
                  pc_r <= target_addr;
               `MIS_OP_CLR:
               begin
                  mem_we_r    <= 1'b1;
                  mem_wdata_r <= `MIS_RST_BYTE;
               end
               `MIS_OP_CLRB:
               begin
                  mem_we_r    <= 1'b1;
                  mem_wdata_r <= bclr;
               end
               `MIS_OP_WDC:
               begin
                  watchdog_counter_r <= {WD_W{1'b0}};
                  prescaler_r        <= {PS_W{1'b0}};
                  powerdown_flag_r   <= 1'b0;
                  timeout_flag_r     <= 1'b0;
               end
               `MIS_OP_WDC1, `MIS_OP_WDC2:
               begin
                  if (wd_both)
                  begin
                     watchdog_counter_r <= {WD_W{1'b0}};
                     prescaler_r        <= {PS_W{1'b0}};
                     powerdown_flag_r   <= 1'b0;
                     timeout_flag_r     <= 1'b0;
                     pre1_r             <= 1'b0;
                     pre2_r             <= 1'b0;
                  end
                  else if (op_code == `MIS_OP_WDC1)
                     pre1_r <= 1'b1;
                  else
                     pre2_r <= 1'b1;
               end
               `MIS_OP_INV_MEM, `MIS_OP_INV_WORK:
               begin
                  if (op_code == `MIS_OP_INV_MEM)
                  begin
                     mem_we_r    <= 1'b1;
                     mem_wdata_r <= cplv;
                  end
                  else
                     working_register_r <= cplv;
                  result_null_flag_r <= (cplv == 8'h00);
               end
               `MIS_OP_BCD_ADJ:
               begin
                  mem_we_r                <= 1'b1;
                  mem_wdata_r             <= {hi_nib, lo_nib};
                  low_nibble_adjust_out_r <= lo_adj;
                  if (hi_fix)
                     bit_seven_out_r <= 1'b1;
               end
               `MIS_OP_DEC, `MIS_OP_DEC_WORK:
               begin
                  if (op_code == `MIS_OP_DEC)
                  begin
                     mem_we_r    <= 1'b1;
                     mem_wdata_r <= decv;
                  end
                  else
                     working_register_r <= decv;
                  result_null_flag_r <= (decv == 8'h00);
               end
               `MIS_OP_INC, `MIS_OP_INC_WORK:
               begin
                  if (op_code == `MIS_OP_INC)
                  begin
                     mem_we_r    <= 1'b1;
                     mem_wdata_r <= incv;
                  end
                  else
                     working_register_r <= incv;
                  result_null_flag_r <= (incv == 8'h00);
               end
               `MIS_OP_HALT:
               begin
                  halted_r           <= 1'b1;
                  watchdog_counter_r <= {WD_W{1'b0}};
                  prescaler_r        <= {PS_W{1'b0}};
                  powerdown_flag_r   <= 1'b1;
                  timeout_flag_r     <= 1'b0;
               end
               default:
                  pc_r <= pc_r + {{(PC_W-1){1'b0}}, 1'b1};
            endcase
         end
      end
   end

endmodule // mis_core

// ### core/mis_regs.vh
// constants for the instruction execution unit
// Contract
// - add memory, working register and carry; result to working or memory.
// - plain add memory or immediate, no carry-in; update wrap, null, half carry, carry.
// - and with memory or immediate to working or memory; only null flag changes.
// - call pushes incremented counter, loads target; no flag changes.
// - clear byte writes zero to memory; flags unchanged.
// - bit clear zeroes selected bit only; flags unchanged.
// - watchdog clear zeroes counter, clears powerdown and timeout flags.
// - paired pre-clears clear watchdog only when both have run.
// - complement to memory or working register; only null flag changes.
// - decimal adjust low nibble plus 6 when above 9 or half carry.
// - decimal adjust high nibble plus low adjust, plus 6 when above 9 or carry; result to memory.
// - decrement to memory or working register; only null flag changes.
// - increment to memory or working register; only null flag changes.
// - halt stops, clears watchdog, advances counter, sets powerdown, clears timeout.
// - jump loads counter with target, stack untouched.
`ifndef MIS_REGS_VH
`define MIS_REGS_VH
`define MIS_OP_NOP    5'h00
`define MIS_OP_ADC    5'h01
`define MIS_OP_ADC_MEM 5'h02
`define MIS_OP_ADD    5'h03
`define MIS_OP_ADDI   5'h04
`define MIS_OP_ADD_MEM 5'h05
`define MIS_OP_AND    5'h06
`define MIS_OP_ANDI   5'h07
`define MIS_OP_AND_MEM 5'h08
`define MIS_OP_CALL   5'h09
`define MIS_OP_CLR    5'h0A
`define MIS_OP_CLRB   5'h0B
`define MIS_OP_WDC    5'h0C
`define MIS_OP_WDC1   5'h0D
`define MIS_OP_WDC2   5'h0E
`define MIS_OP_INV_MEM  5'h0F
`define MIS_OP_INV_WORK 5'h10
`define MIS_OP_BCD_ADJ  5'h11
`define MIS_OP_DEC    5'h12
`define MIS_OP_DEC_WORK 5'h13
`define MIS_OP_HALT   5'h14
`define MIS_OP_INC    5'h15
`define MIS_OP_INC_WORK 5'h16
`define MIS_OP_JMP    5'h17
`define MIS_BCD_LIMIT 4'h9
`define MIS_BCD_FIX   4'h6
`define MIS_RST_BYTE  8'h00
`define MIS_RST_PC    12'h000
`endif

// ### test/mis_core_asserts.sv
// concurrent checks on the execution unit ports
`include "mis_regs.vh"
module mis_core_asserts #(parameter PC_W = 12, parameter WD_W = 8, parameter PS_W = 8) (
   // clock, reset and issue
   input wire            clk, rst, op_valid,
   input wire [4:0]      op_code,
   input wire [7:0]      mem_data,
   input wire [2:0]      bit_sel,
   input wire [PC_W-1:0] target_addr,
   // results
   input wire            mem_we_r, push_r, halted_r, result_null_flag_r, bit_seven_out_r,
   input wire            half_carry_flag_r, powerdown_flag_r, timeout_flag_r,
   input wire [7:0]      mem_wdata_r, working_register_r,
   input wire [PC_W-1:0] push_data_r, pc_r,
   input wire [WD_W-1:0] watchdog_counter_r,
   input wire [PS_W-1:0] prescaler_r
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   wire go = op_valid && !halted_r;
   call_push_a: assert property (
      go && op_code == `MIS_OP_CALL |=> push_r && push_data_r == $past(pc_r) + 1'b1 && pc_r == $past(target_addr))
      else $error("call push or target wrong");
   jump_load_a: assert property (
      go && op_code == `MIS_OP_JMP |=> pc_r == $past(target_addr) && !push_r)
      else $error("jump target wrong");
   clear_byte_a: assert property (
      go && op_code == `MIS_OP_CLR |=> mem_we_r && mem_wdata_r == 8'h00 && $stable(bit_seven_out_r))
      else $error("byte clear wrong");
   bit_clear_a: assert property (
      go && op_code == `MIS_OP_CLRB |=> mem_we_r && mem_wdata_r == ($past(mem_data) & ~(8'h01 << $past(bit_sel))))
      else $error("bit clear wrong");
   wd_clear_a: assert property (
      go && op_code == `MIS_OP_WDC |=> watchdog_counter_r == 0 && !powerdown_flag_r && !timeout_flag_r)
      else $error("watchdog clear wrong");
   halt_entry_a: assert property (
      go && op_code == `MIS_OP_HALT |=> halted_r && powerdown_flag_r && !timeout_flag_r
      && pc_r == $past(pc_r) + 1'b1 && watchdog_counter_r == 0 && prescaler_r == 0) else $error("halt entry wrong");
   halt_hold_a: assert property (
      halted_r |=> halted_r && $stable(pc_r) && $stable(working_register_r) && !mem_we_r && !push_r)
      else $error("state moved while halted");
   invert_mem_a: assert property (
      go && op_code == `MIS_OP_INV_MEM |=> mem_we_r && mem_wdata_r == ~$past(mem_data) && $stable(bit_seven_out_r))
      else $error("complement wrong");
   inc_work_a: assert property (
      go && op_code == `MIS_OP_INC_WORK |=> !mem_we_r && working_register_r == $past(mem_data) + 8'h01
      && result_null_flag_r == (working_register_r == 8'h00)) else $error("increment to working wrong");
   dec_mem_a: assert property (
      go && op_code == `MIS_OP_DEC |=> mem_we_r && mem_wdata_r == $past(mem_data) - 8'h01 && $stable(half_carry_flag_r))
      else $error("decrement wrong");
   and_mask_a: assert property (
      go && op_code == `MIS_OP_AND |=> working_register_r == ($past(working_register_r) & $past(mem_data))
      && $stable(bit_seven_out_r)) else $error("and wrong");
endmodule // mis_core_asserts
bind mis_core mis_core_asserts #(.PC_W(PC_W), .WD_W(WD_W), .PS_W(PS_W)) i_mis_core_asserts (
   .clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code), .mem_data(mem_data), .bit_sel(bit_sel),
   .target_addr(target_addr), .mem_we_r(mem_we_r), .push_r(push_r), .halted_r(halted_r),
   .result_null_flag_r(result_null_flag_r), .bit_seven_out_r(bit_seven_out_r), .half_carry_flag_r(half_carry_flag_r),
   .powerdown_flag_r(powerdown_flag_r), .timeout_flag_r(timeout_flag_r), .mem_wdata_r(mem_wdata_r),
   .working_register_r(working_register_r), .push_data_r(push_data_r), .pc_r(pc_r),
   .watchdog_counter_r(watchdog_counter_r), .prescaler_r(prescaler_r));

// ### test/mis_core_test.sv
// self-checking bench for the execution unit
`include "mis_regs.vh"
module mis_core_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, rst = 1, op_valid = 0;
   logic [4:0]  op_code = 0;
   logic [7:0]  mem_data = 0, imm_data = 0;
   logic [2:0]  bit_sel = 0;
   logic [11:0] target_addr = 0;
   wire         mem_we_r, push_r, result_null_flag_r, bit_seven_out_r, half_carry_flag_r, signed_wrap_flag_r;
   wire         powerdown_flag_r, timeout_flag_r, low_nibble_adjust_out_r, halted_r;
   wire [7:0]   mem_wdata_r, working_register_r;
   wire [11:0]  push_data_r, pc_r;
   wire [3:0]   watchdog_counter_r;
   wire [1:0]   prescaler_r;
   int          n_mismatch = 0, n_checks = 0;
   // short prescaler so the watchdog ticks every four cycles
   mis_core #(.WD_W(4), .PS_W(2)) i_mis_core (.clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
      .mem_data(mem_data), .imm_data(imm_data), .bit_sel(bit_sel), .target_addr(target_addr), .mem_we_r(mem_we_r),
      .mem_wdata_r(mem_wdata_r), .push_r(push_r), .push_data_r(push_data_r), .pc_r(pc_r),
      .working_register_r(working_register_r), .result_null_flag_r(result_null_flag_r),
      .bit_seven_out_r(bit_seven_out_r), .half_carry_flag_r(half_carry_flag_r),
      .signed_wrap_flag_r(signed_wrap_flag_r),
      .powerdown_flag_r(powerdown_flag_r), .timeout_flag_r(timeout_flag_r), .halted_r(halted_r),
      .low_nibble_adjust_out_r(low_nibble_adjust_out_r), .watchdog_counter_r(watchdog_counter_r),
      .prescaler_r(prescaler_r));
   initial forever #50 clk = ~clk;
   task chk(input logic [15:0] s, e);
      n_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
      end
   endtask
   // one op, then memory strobe, working value and null flag
   task t(input logic [4:0] c, input logic [7:0] m, input logic we, input logic [7:0] wd, w, input logic z);
      op_code = c;
      mem_data = m;
      imm_data = m;
      op_valid = 1;
      @(posedge clk);
      #1;
      chk(mem_we_r, we);
      if (we)
         chk(mem_wdata_r, wd);
      chk(working_register_r, w);
      chk(result_null_flag_r, z);
   endtask
   task cf(input logic c, h, v);
      chk(bit_seven_out_r, c);
      chk(half_carry_flag_r, h);
      chk(signed_wrap_flag_r, v);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task t_arith;
      t(`MIS_OP_ADD, 8'h78, 0, 0, 8'h78, 0);
      t(`MIS_OP_ADDI, 8'h88, 0, 0, 8'h00, 1);
      cf(1, 1, 0);
      t(`MIS_OP_ADC, 8'h05, 0, 0, 8'h06, 0);
      cf(0, 0, 0);
      t(`MIS_OP_ADC_MEM, 8'h7A, 1, 8'h80, 8'h06, 0);
      cf(0, 1, 1);
      t(`MIS_OP_AND_MEM, 8'h09, 1, 8'h00, 8'h06, 1);
      t(`MIS_OP_ANDI, 8'h04, 0, 0, 8'h04, 0);
      t(`MIS_OP_AND, 8'hFF, 0, 0, 8'h04, 0);
      cf(0, 1, 1);
      chk(pc_r, 12'h007);
      $display("t_arith done");
   endtask
   task t_unary;
      bit_sel = 3'h5;
      t(`MIS_OP_ADDI, 8'hFC, 0, 0, 8'h00, 1);
      t(`MIS_OP_INC, 8'hFF, 1, 8'h00, 8'h00, 1);
      t(`MIS_OP_CLR, 8'hAB, 1, 8'h00, 8'h00, 1);
      t(`MIS_OP_INV_MEM, 8'hA5, 1, 8'h5A, 8'h00, 0);
      t(`MIS_OP_INV_WORK, 8'hFF, 0, 0, 8'h00, 1);
      t(`MIS_OP_DEC, 8'h01, 1, 8'h00, 8'h00, 1);
      t(`MIS_OP_CLRB, 8'hFF, 1, 8'hDF, 8'h00, 1);
      t(`MIS_OP_DEC_WORK, 8'h00, 0, 0, 8'hFF, 0);
      t(`MIS_OP_INC_WORK, 8'h41, 0, 0, 8'h42, 0);
      cf(1, 1, 0);
      $display("t_unary done");
   endtask
   task t_daa;
      t(`MIS_OP_ADDI, 8'h59, 0, 0, 8'h9B, 0);
      t(`MIS_OP_BCD_ADJ, 8'h00, 1, 8'h01, 8'h9B, 0);
      chk(low_nibble_adjust_out_r, 1);
      cf(1, 0, 1);
      t(`MIS_OP_ANDI, 8'h00, 0, 0, 8'h00, 1);
      t(`MIS_OP_ADD, 8'h34, 0, 0, 8'h34, 0);
      t(`MIS_OP_BCD_ADJ, 8'h00, 1, 8'h34, 8'h34, 0);
      chk(low_nibble_adjust_out_r, 0);
      cf(0, 0, 0);
      t(`MIS_OP_ADD_MEM, 8'h4C, 1, 8'h80, 8'h34, 0);
      cf(0, 1, 1);
      $display("t_daa done");
   endtask
   task t_flow;
      target_addr = 12'h3F0;
      t(`MIS_OP_JMP, 8'h00, 0, 0, 8'h34, 0);
      chk({push_r, pc_r}, 16'h03F0);
      target_addr = 12'h123;
      t(`MIS_OP_CALL, 8'h00, 0, 0, 8'h34, 0);
      chk(push_r, 1);
      chk(push_data_r, 12'h3F1);
      chk(pc_r, 12'h123);
      t(`MIS_OP_NOP, 8'h00, 0, 0, 8'h34, 0);
      chk({push_r, pc_r}, 16'h0124);
      $display("t_flow done");
   endtask
   task t_wdt;
      t(`MIS_OP_WDC, 8'h00, 0, 0, 8'h34, 0);
      chk({watchdog_counter_r, powerdown_flag_r, timeout_flag_r}, 0);
      op_code = `MIS_OP_NOP;
      repeat (6) @(posedge clk);
      #1;
      t(`MIS_OP_WDC1, 8'h00, 0, 0, 8'h34, 0);
      chk(watchdog_counter_r != 0, 1);
      t(`MIS_OP_WDC1, 8'h00, 0, 0, 8'h34, 0);
      chk(watchdog_counter_r != 0, 1);
      t(`MIS_OP_WDC2, 8'h00, 0, 0, 8'h34, 0);
      chk({watchdog_counter_r, prescaler_r}, 0);
      t(`MIS_OP_HALT, 8'h00, 0, 0, 8'h34, 0);
      chk({halted_r, powerdown_flag_r, timeout_flag_r, watchdog_counter_r, prescaler_r}, 9'h180);
      chk(pc_r, 12'h12F);
      t(`MIS_OP_ADDI, 8'h11, 0, 0, 8'h34, 0);
      chk(pc_r, 12'h12F);
      rst = 1;
      @(posedge clk);
      #1;
      rst = 0;
      chk({halted_r, powerdown_flag_r, pc_r}, 0);
      $display("t_wdt done");
   endtask
   initial
   begin
      #100000;
      n_mismatch++;
      complete_run();
   end
   initial
   begin
      repeat (2) @(posedge clk);
      #1;
      rst = 0;
      t_arith();
      t_unary();
      t_daa();
      t_flow();
      t_wdt();
      complete_run();
   end
endmodule // mis_core_test
